// File: iwu_defines.vh
// Register map, field codes and timing constants of the interrupt and watchdog unit
`ifndef IWU_DEFINES_VH
`define IWU_DEFINES_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define IWU_MF_CFG_BASE      16'h0200
`define IWU_MF_CFG_LAST      16'h0207
`define IWU_PIN_MODE_ADDR    16'h0208
`define IWU_MASK_BASE        16'h0209
`define IWU_MASK_LAST        16'h0210
`define IWU_WDOG_LO_ADDR     16'h0211
`define IWU_WDOG_HI_ADDR     16'h0212
`define IWU_RESET_FN_ADDR    16'h0a03
`define IWU_CLEAR_BASE       16'h0a04
`define IWU_CLEAR_LAST       16'h0a0b
`define IWU_PENDING_BASE     16'h0d02
`define IWU_PENDING_LAST     16'h0d09

// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define IWU_RST_WDOG_BIT     0
`define IWU_RST_IRQ_BIT      1
`define IWU_MF_DIR_BIT       7
`define IWU_MF_FN_WDOG_RST   7'h03
`define IWU_MF_FN_IRQ_RST    7'h04
`define IWU_MODE_OD_LOW      2'h0
`define IWU_MODE_OD_HIGH     2'h1
`define IWU_MODE_PP_HIGH     2'h2
`define IWU_MODE_PP_LOW      2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IWU_PIN_MODE_RST     8'h00
`define IWU_MASK_RST         64'h0000_0000_0000_0000
`define IWU_WDOG_RST         16'h0000
`define IWU_MF_CFG_RST       8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define IWU_CLK_PERIOD_NS    10
`define IWU_WDOG_UNIT_NS     1000000
`define IWU_MS_CYCLES        (`IWU_WDOG_UNIT_NS / `IWU_CLK_PERIOD_NS)
`define IWU_WDOG_PULSE_CYC   32

`endif

// File: iwu_irq_watchdog.v
// Interrupt monitor, mask, clear, pin driver and millisecond watchdog
`timescale 1ns/1ps
`default_nettype none
`include "iwu_defines.vh"

module iwu_irq_watchdog #(
   parameter integer NUM_SRC      = 64,
   parameter integer NUM_MF       = 8,
   parameter integer WDOG_SRC_BIT = 0,
   parameter [6:0]   MF_FN_WDOG_OUT = 7'h01,
   parameter integer MS_CYCLES    = `IWU_MS_CYCLES
) (
   input  wire                clock_in,
   input  wire                reset_in,
   input  wire [15:0]         reg_addr_in,
   input  wire [7:0]          reg_wdata_in,
   input  wire                reg_wr_in,
   input  wire                reg_rd_in,
   output reg  [7:0]          reg_rdata_out,
   input  wire [NUM_SRC-1:0]  irq_src_in,
   input  wire [NUM_MF-1:0]   mf_pins_in,
   output reg  [NUM_MF-1:0]   mf_pins_out,
   output reg  [NUM_MF-1:0]   mf_pins_oe_out,
   output reg                 irq_pin_out,
   output reg                 irq_pin_oe_out,
   output wire                wdog_timeout_out
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   reg  [7:0]           pin_mode_q;
   reg  [NUM_SRC-1:0]   mask_q;
   reg  [NUM_SRC-1:0]   pending_q;
   reg  [NUM_SRC-1:0]   pending_d;
   reg  [15:0]          wdog_period_q;
   reg  [7:0]           mf_cfg_q [0:NUM_MF-1];
   reg  [31:0]          div_q;
   reg  [15:0]          ms_cnt_q;
   reg  [5:0]           pulse_cnt_q;
   reg                  wdog_tick_q;

   wire                 wr_reset_fn;
   wire                 wr_clear;
   wire [15:0]          clear_off;
   wire [15:0]          mask_off;
   wire [15:0]          pend_off;
   wire [2:0]           clear_byte;
   wire [2:0]           mask_byte;
   wire [2:0]           pend_byte;
   reg  [NUM_SRC-1:0]   clear_vec;
   reg                  pin_wdog_rst;
   reg                  pin_irq_rst;
   reg                  found_wdog;
   reg                  found_irq;
   wire                 clear_all;
   wire                 wdog_restart;
   wire                 wdog_enabled;
   wire                 ms_tick;
   wire                 wdog_timeout;
   wire                 irq_active;
   reg  [NUM_SRC-1:0]   src_vec;
   integer              i;
   integer              j;
   integer              k;

   // Length of the stretched timeout pulse
   localparam [5:0]     PULSE_LEN = `IWU_WDOG_PULSE_CYC;

   assign wr_reset_fn = reg_wr_in && (reg_addr_in == `IWU_RESET_FN_ADDR);
   assign wr_clear    = reg_wr_in && (reg_addr_in >= `IWU_CLEAR_BASE) && (reg_addr_in <= `IWU_CLEAR_LAST);
   // Byte lanes of the 64-bit registers, cut to three bits on purpose
   assign clear_off   = reg_addr_in - `IWU_CLEAR_BASE;
   assign mask_off    = reg_addr_in - `IWU_MASK_BASE;
   assign pend_off    = reg_addr_in - `IWU_PENDING_BASE;
   assign clear_byte  = clear_off[2:0];
   assign mask_byte   = mask_off[2:0];
   assign pend_byte   = pend_off[2:0];

   // ----------------------------------------------------------------
   // Multifunction pin control inputs
   // ----------------------------------------------------------------
   // input decode: MSB low selects input function
   // lowest index: first matching pin takes control
   always @* begin
      pin_wdog_rst = 1'b0;
      pin_irq_rst  = 1'b0;
      found_wdog   = 1'b0;
      found_irq    = 1'b0;
      for (i = 0; i < NUM_MF; i = i + 1) begin
         if (!mf_cfg_q[i][`IWU_MF_DIR_BIT]) begin
            if (!found_wdog && (mf_cfg_q[i][6:0] == `IWU_MF_FN_WDOG_RST)) begin
               found_wdog   = 1'b1;
               pin_wdog_rst = mf_pins_in[i];
            end
            if (!found_irq && (mf_cfg_q[i][6:0] == `IWU_MF_FN_IRQ_RST)) begin
               found_irq   = 1'b1;
               pin_irq_rst = mf_pins_in[i];
            end
         end
      end
   end

   // reset-all: write pulse only, nothing stored
   // pin clear: same path as control bit
   assign clear_all = (wr_reset_fn && reg_wdata_in[`IWU_RST_IRQ_BIT]) || pin_irq_rst;

   assign wdog_restart = (wr_reset_fn && reg_wdata_in[`IWU_RST_WDOG_BIT]) || pin_wdog_rst;

   // ----------------------------------------------------------------
   // Clear vector from the autoclearing clear register
   // ----------------------------------------------------------------
   // per-bit clear, acts only in the write cycle
   always @* begin
      clear_vec = {NUM_SRC{clear_all}};
      if (wr_clear) begin
         clear_vec[clear_byte*8 +: 8] = clear_vec[clear_byte*8 +: 8] | reg_wdata_in;
      end
   end

   // ----------------------------------------------------------------
   // Monitor register update
   // ----------------------------------------------------------------
   // watchdog timeout joins the sources
   always @* begin
      src_vec = irq_src_in;
      src_vec[WDOG_SRC_BIT] = irq_src_in[WDOG_SRC_BIT] | wdog_timeout;
   end

   // sticky set, mask gates only setting, set beats clear
   always @* begin
      pending_d = (pending_q & ~clear_vec) | (src_vec & mask_q);
   end

   always @(posedge clock_in) begin
      if (reset_in) begin
         pending_q <= {NUM_SRC{1'b0}};
      end else begin
         pending_q <= pending_d;
      end
   end

   // ----------------------------------------------------------------
   // Software writable registers
   // ----------------------------------------------------------------
   always @(posedge clock_in) begin
      if (reset_in) begin
         pin_mode_q    <= `IWU_PIN_MODE_RST;
         mask_q        <= `IWU_MASK_RST;
         wdog_period_q <= `IWU_WDOG_RST;
         for (j = 0; j < NUM_MF; j = j + 1) begin
            mf_cfg_q[j] <= `IWU_MF_CFG_RST;
         end
      end else if (reg_wr_in) begin
         if ((reg_addr_in >= `IWU_MF_CFG_BASE) && (reg_addr_in <= `IWU_MF_CFG_LAST)) begin
            mf_cfg_q[reg_addr_in[2:0]] <= reg_wdata_in;
         end else if (reg_addr_in == `IWU_PIN_MODE_ADDR) begin
            pin_mode_q <= reg_wdata_in;
         end else if ((reg_addr_in >= `IWU_MASK_BASE) && (reg_addr_in <= `IWU_MASK_LAST)) begin
            mask_q[mask_byte*8 +: 8] <= reg_wdata_in;
         end else if (reg_addr_in == `IWU_WDOG_LO_ADDR) begin
            wdog_period_q[7:0] <= reg_wdata_in;
         end else if (reg_addr_in == `IWU_WDOG_HI_ADDR) begin
            wdog_period_q[15:8] <= reg_wdata_in;
         end
      end
   end

   // ----------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------
   // Clear and reset-function registers read as zero
   always @(posedge clock_in) begin
      if (reset_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         if ((reg_addr_in >= `IWU_MF_CFG_BASE) && (reg_addr_in <= `IWU_MF_CFG_LAST)) begin
            reg_rdata_out <= mf_cfg_q[reg_addr_in[2:0]];
         end else if (reg_addr_in == `IWU_PIN_MODE_ADDR) begin
            reg_rdata_out <= pin_mode_q;
         end else if ((reg_addr_in >= `IWU_MASK_BASE) && (reg_addr_in <= `IWU_MASK_LAST)) begin
            reg_rdata_out <= mask_q[mask_byte*8 +: 8];
         end else if (reg_addr_in == `IWU_WDOG_LO_ADDR) begin
            reg_rdata_out <= wdog_period_q[7:0];
         end else if (reg_addr_in == `IWU_WDOG_HI_ADDR) begin
            reg_rdata_out <= wdog_period_q[15:8];
         end else if ((reg_addr_in >= `IWU_PENDING_BASE) && (reg_addr_in <= `IWU_PENDING_LAST)) begin
            reg_rdata_out <= pending_q[pend_byte*8 +: 8];
         end else begin
            reg_rdata_out <= 8'h00;
         end
      end
   end

   // ----------------------------------------------------------------
   // Watchdog
   // ----------------------------------------------------------------
   // zero period disables
   assign wdog_enabled = (wdog_period_q != 16'h0000);
   // exact cycle count, accuracy set by the clock
   assign ms_tick      = (div_q == MS_CYCLES - 1);
   assign wdog_timeout = wdog_enabled && ms_tick && !wdog_restart && (ms_cnt_q == wdog_period_q - 16'h0001);

   // continuous count, restart after each timeout
   always @(posedge clock_in) begin
      if (reset_in || !wdog_enabled || wdog_restart) begin
         div_q    <= 32'h0000_0000;
         ms_cnt_q <= 16'h0000;
      end else if (ms_tick) begin
         div_q    <= 32'h0000_0000;
         if (wdog_timeout) begin
            ms_cnt_q <= 16'h0000;
         end else begin
            ms_cnt_q <= ms_cnt_q + 16'h0001;
         end
      end else begin
         div_q <= div_q + 32'h0000_0001;
      end
   end

   always @(posedge clock_in) begin
      if (reset_in) begin
         pulse_cnt_q <= 6'h00;
         wdog_tick_q <= 1'b0;
      end else begin
         wdog_tick_q <= wdog_timeout;
         if (wdog_timeout) begin
            pulse_cnt_q <= PULSE_LEN;
         end else if (pulse_cnt_q != 6'h00) begin
            pulse_cnt_q <= pulse_cnt_q - 6'h01;
         end
      end
   end

   assign wdog_timeout_out = wdog_tick_q;

   // Multifunction outputs: watchdog pulse on output pins set to MF_FN_WDOG_OUT
   always @(posedge clock_in) begin
      if (reset_in) begin
         mf_pins_out    <= {NUM_MF{1'b0}};
         mf_pins_oe_out <= {NUM_MF{1'b0}};
      end else begin
         for (k = 0; k < NUM_MF; k = k + 1) begin
            mf_pins_oe_out[k] <= mf_cfg_q[k][`IWU_MF_DIR_BIT];
            mf_pins_out[k]    <= mf_cfg_q[k][`IWU_MF_DIR_BIT] &&
                                 (mf_cfg_q[k][6:0] == MF_FN_WDOG_OUT) && (pulse_cnt_q != 6'h00);
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupt pin driver
   // ----------------------------------------------------------------
   // OR of all pending bits, held until all cleared
   assign irq_active = |pending_q;

   always @(posedge clock_in) begin
      if (reset_in) begin
         irq_pin_out    <= 1'b0;
         irq_pin_oe_out <= 1'b0;
      end else begin
         case (pin_mode_q[1:0])
            // open drain, float or pull low
            `IWU_MODE_OD_LOW: begin
               irq_pin_out    <= 1'b0;
               irq_pin_oe_out <= irq_active;
            end
            `IWU_MODE_OD_HIGH: begin
               irq_pin_out    <= 1'b1;
               irq_pin_oe_out <= irq_active;
            end
            `IWU_MODE_PP_HIGH: begin
               irq_pin_out    <= irq_active;
               irq_pin_oe_out <= 1'b1;
            end
            default: begin
               irq_pin_out    <= ~irq_active;
               irq_pin_oe_out <= 1'b1;
            end
         endcase
      end
   end

endmodule // iwu_irq_watchdog
`default_nettype wire

// File: iwu_checker.sv
// Assertion checker for the interrupt and watchdog unit
`timescale 1ns/1ps
`default_nettype none
module iwu_checker #(
   parameter int NUM_SRC   = 64,
   parameter int NUM_MF    = 8,
   parameter int MS_CYCLES = 4
) (
   input wire logic               clock_in,
   input wire logic               reset_in,
   input wire logic [15:0]        reg_addr_in,
   input wire logic [7:0]         reg_wdata_in,
   input wire logic               reg_wr_in,
   input wire logic               reg_rd_in,
   input wire logic [7:0]         reg_rdata_out,
   input wire logic [NUM_SRC-1:0] irq_src_in,
   input wire logic [NUM_MF-1:0]  mf_pins_in,
   input wire logic [NUM_MF-1:0]  mf_pins_out,
   input wire logic [NUM_MF-1:0]  mf_pins_oe_out,
   input wire logic               irq_pin_out,
   input wire logic               irq_pin_oe_out,
   input wire logic               wdog_timeout_out
);
   logic [1:0] mode_q;
   logic [7:0] rst_cnt_q;
   logic [7:0] pls_cnt_q;
   wire        rst_wr = reg_wr_in && (reg_addr_in == 16'h0a03);
   // Pin asserted level, decoded through the shadow mode
   wire        act    = mode_q[1] ? (irq_pin_out ^ mode_q[0]) : irq_pin_oe_out;
   // Shadow of pin mode, cycles since restart, pulse length
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         mode_q    <= 2'h0;
         rst_cnt_q <= 8'h00;
         pls_cnt_q <= 8'h00;
      end else begin
         if (reg_wr_in && reg_addr_in == 16'h0208) mode_q <= reg_wdata_in[1:0];
         if (rst_wr && reg_wdata_in[0]) rst_cnt_q <= 8'h00;
         else if (rst_cnt_q != 8'hff) rst_cnt_q <= rst_cnt_q + 8'h01;
         pls_cnt_q <= mf_pins_out[0] ? pls_cnt_q + 8'h01 : 8'h00;
      end
   end
   property p_reset_idle;
      @(posedge clock_in) reset_in |=> !irq_pin_oe_out && !irq_pin_out && !wdog_timeout_out;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
   property p_od_mode;
      @(posedge clock_in) disable iff (reset_in)
      (!mode_q[1] && mode_q == $past(mode_q)) |-> irq_pin_out == mode_q[0];
   endproperty
   a_od_mode: assert property (p_od_mode) else $error("open drain level wrong");
   property p_pp_mode;
      @(posedge clock_in) disable iff (reset_in) (mode_q[1] && mode_q == $past(mode_q)) |-> irq_pin_oe_out;
   endproperty
   a_pp_mode: assert property (p_pp_mode) else $error("push pull not driving");
   property p_clear_all;
      @(posedge clock_in) disable iff (reset_in)
      (rst_wr && reg_wdata_in[1] && irq_src_in == '0 && mode_q == $past(mode_q)) |->
      ##2 (!act || $past(wdog_timeout_out));
   endproperty
   a_clear_all: assert property (p_clear_all) else $error("clear all left pin asserted");
   property p_clr_zero;
      @(posedge clock_in) disable iff (reset_in)
      (reg_rd_in && reg_addr_in >= 16'h0a03 && reg_addr_in <= 16'h0a0b) |=> reg_rdata_out == 8'h00;
   endproperty
   a_clr_zero: assert property (p_clr_zero) else $error("clear register not zero");
   property p_pulse_len;
      @(posedge clock_in) disable iff (reset_in) $fell(mf_pins_out[0]) |-> pls_cnt_q == 8'd32;
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("timeout pulse length wrong");
   property p_pulse_cause;
      @(posedge clock_in) disable iff (reset_in) $rose(mf_pins_out[0]) |-> $past(wdog_timeout_out);
   endproperty
   a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without timeout");
   property p_tmo_single;
      @(posedge clock_in) disable iff (reset_in) wdog_timeout_out |=> !wdog_timeout_out [*3];
   endproperty
   a_tmo_single: assert property (p_tmo_single) else $error("timeouts too close");
   property p_restart;
      @(posedge clock_in) disable iff (reset_in) wdog_timeout_out |-> rst_cnt_q >= MS_CYCLES - 1;
   endproperty
   a_restart: assert property (p_restart) else $error("timeout soon after restart");
endmodule // iwu_checker
bind iwu_irq_watchdog iwu_checker #(.NUM_SRC(NUM_SRC), .NUM_MF(NUM_MF), .MS_CYCLES(MS_CYCLES)) iwu_checker_inst (
   .clock_in(clock_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
   .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .irq_src_in(irq_src_in),
   .mf_pins_in(mf_pins_in), .mf_pins_out(mf_pins_out), .mf_pins_oe_out(mf_pins_oe_out),
   .irq_pin_out(irq_pin_out), .irq_pin_oe_out(irq_pin_oe_out), .wdog_timeout_out(wdog_timeout_out));
`default_nettype wire

// File: iwu_host_model.sv
// Host model: register port master that services interrupts
`timescale 1ns/1ps
`default_nettype none
module iwu_host_model (
   input  wire logic        clock_in,
   input  wire logic [7:0]  rdata_in,
   output var  logic [15:0] addr_out,
   output var  logic [7:0]  wdata_out,
   output var  logic        wr_out,
   output var  logic        rd_out
);
   initial begin
      addr_out  = 16'h0000;
      wdata_out = 8'h00;
      wr_out    = 1'b0;
      rd_out    = 1'b0;
   end
   // Byte write held to the taking edge, then data inverted
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock_in);
      addr_out  <= a;
      wdata_out <= d;
      wr_out    <= 1'b1;
      @(posedge clock_in);
      wr_out    <= 1'b0;
      wdata_out <= ~d;
   endtask
   // Byte read, data taken one cycle after the read edge
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clock_in);
      addr_out <= a;
      rd_out   <= 1'b1;
      @(posedge clock_in);
      rd_out   <= 1'b0;
      @(posedge clock_in);
      #1 d = rdata_in;
   endtask
   task automatic service(input logic [15:0] a, output logic [7:0] d);
      rd(a, d);
      wr(a - 16'h0d02 + 16'h0a04, d);
   endtask
endmodule // iwu_host_model
`default_nettype wire

// File: tb_irq_and_watchdog_unit.sv
// Self-checking testbench of the interrupt and watchdog unit
`timescale 1ns/1ps
`default_nettype none
module tb_irq_and_watchdog_unit;
   localparam int MS = 4;
   logic        clock_in;
   logic        reset_in;
   logic [15:0] reg_addr;
   logic [7:0]  wdata, rdata, mf_in, mf_out, mf_oe, d;
   logic        reg_wr, reg_rd, irq_pin, irq_oe, tmo;
   logic [63:0] src;
   int          err_total = 0, num_checks = 0, cyc = 0, tmo_cnt = 0, n, t0;
   iwu_irq_watchdog #(.MS_CYCLES(MS)) iwu_irq_watchdog_inst (
      .clock_in(clock_in), .reset_in(reset_in), .reg_addr_in(reg_addr), .reg_wdata_in(wdata),
      .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .irq_src_in(src),
      .mf_pins_in(mf_in), .mf_pins_out(mf_out), .mf_pins_oe_out(mf_oe), .irq_pin_out(irq_pin),
      .irq_pin_oe_out(irq_oe), .wdog_timeout_out(tmo));
   iwu_host_model host (.clock_in(clock_in), .rdata_in(rdata), .addr_out(reg_addr),
      .wdata_out(wdata), .wr_out(reg_wr), .rd_out(reg_rd));
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   // Cycle ceiling and timeout pulse count
   always @(posedge clock_in) begin
      cyc++;
      if (tmo === 1'b1) tmo_cnt++;
      if (cyc == 5000) begin
         err_total++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic pulse(input int b);
      @(posedge clock_in) src[b] <= 1'b1;
      @(posedge clock_in) src[b] <= 1'b0;
   endtask
   task automatic settle();
      repeat (2) @(posedge clock_in);
      #1;
   endtask
   task automatic wait_tmo(output int k);
      k = 0;
      do begin
         @(posedge clock_in);
         #1 k++;
      end while (tmo !== 1'b1 && k < 200);
   endtask
   task automatic t_reset();
      host.rd(16'h020a, d);
      chk("mask", d, 8'h00);
      host.rd(16'h0211, d);
      chk("wdog", d, 8'h00);
      chk("irq_oe", irq_oe, 1'b0);
      $display("test reset done");
   endtask
   task automatic t_irq();
      host.wr(16'h020a, 8'h03);
      pulse(8);
      pulse(9);
      settle();
      chk("irq_oe", irq_oe, 1'b1);
      host.wr(16'h020a, 8'h00);
      pulse(10);
      host.rd(16'h0d03, d);
      chk("pending", d, 8'h03);
      host.wr(16'h0a05, 8'h01);
      host.rd(16'h0d03, d);
      chk("pending", d, 8'h02);
      chk("irq_oe", irq_oe, 1'b1);
      host.rd(16'h0a05, d);
      chk("clear", d, 8'h00);
      host.service(16'h0d03, d);
      settle();
      chk("irq_oe", irq_oe, 1'b0);
      host.wr(16'h0210, 8'h80);
      host.rd(16'h0210, d);
      chk("mask_top", d, 8'h80);
      pulse(63);
      host.rd(16'h0d09, d);
      chk("pending_top", d, 8'h80);
      host.wr(16'h0a0b, 8'h80);
      host.rd(16'h0d09, d);
      chk("clear_top", d, 8'h00);
      $display("test irq done");
   endtask
   task automatic t_modes();
      host.wr(16'h020a, 8'h01);
      for (int m = 0; m < 4; m++) begin
         host.wr(16'h0208, m[7:0]);
         settle();
         chk("idle_out", irq_pin, m[0]);
         chk("idle_oe", irq_oe, m[1]);
         pulse(8);
         settle();
         chk("act_out", irq_pin, m[1] ^ m[0]);
         chk("act_oe", irq_oe, 1'b1);
         host.wr(16'h0a03, 8'h02);
         settle();
         chk("clr_oe", irq_oe, m[1]);
      end
      host.wr(16'h0208, 8'h00);
      $display("test modes done");
   endtask
   task automatic t_mix();
      fork
         host.wr(16'h0a05, 8'h01);
         pulse(8);
      join
      host.rd(16'h0d03, d);
      chk("set_wins", d, 8'h01);
      host.wr(16'h0200, 8'h04);
      host.wr(16'h0202, 8'h04);
      @(posedge clock_in) mf_in[2] <= 1'b1;
      repeat (3) @(posedge clock_in);
      mf_in[2] <= 1'b0;
      host.rd(16'h0d03, d);
      chk("pin2_ignored", d, 8'h01);
      @(posedge clock_in) mf_in[0] <= 1'b1;
      repeat (3) @(posedge clock_in);
      mf_in[0] <= 1'b0;
      host.rd(16'h0d03, d);
      chk("pin_clear", d, 8'h00);
      host.wr(16'h0202, 8'h00);
      $display("test mix done");
   endtask
   task automatic t_wdog();
      host.wr(16'h0209, 8'h01);
      host.wr(16'h0200, 8'h81);
      host.wr(16'h0211, 8'h0a);
      wait_tmo(n);
      wait_tmo(n);
      chk("period", n, 10 * MS);
      chk("mf_oe", mf_oe, 8'h01);
      wait_tmo(n);
      @(posedge clock_in);
      #1 n = 0;
      while (mf_out[0] === 1'b1 && n < 100) begin
         n++;
         @(posedge clock_in);
         #1;
      end
      chk("pulse", n, 32);
      host.rd(16'h0d02, d);
      chk("wdog_irq", d[0], 1'b1);
      t0 = tmo_cnt;
      repeat (30) host.wr(16'h0a03, 8'h01);
      chk("restart", tmo_cnt - t0, 0);
      host.wr(16'h0201, 8'h03);
      @(posedge clock_in) mf_in[1] <= 1'b1;
      repeat (60) @(posedge clock_in);
      chk("pin_restart", tmo_cnt - t0, 0);
      mf_in[1] <= 1'b0;
      host.wr(16'h0211, 8'h00);
      t0 = tmo_cnt;
      repeat (100) @(posedge clock_in);
      chk("disabled", tmo_cnt - t0, 0);
      $display("test wdog done");
   endtask
   initial begin
      reset_in = 1'b1;
      src      = '0;
      mf_in    = 8'h00;
      repeat (20) @(posedge clock_in);
      reset_in <= 1'b0;
      t_reset();
      t_irq();
      t_modes();
      t_mix();
      t_wdog();
      test_done();
   end
endmodule // tb_irq_and_watchdog_unit
`default_nettype wire
